/* File: rtl/sfrc_ramp.sv */
// frequency ramp controller with avalon-mm register slave
//
// Chosen here: the register offsets and the Avalon-MM slave port.
`default_nettype none
module sfrc_ramp (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  input  wire logic        pd_tick_in,
  input  wire logic        step_clock_pin_in,
  input  wire logic        step_direction_pin_in,
  input  wire logic        cal_done_in,
  input  wire logic [5:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  output logic [33:0]      frac_numerator_out,
  output logic             recal_req_out
);
  localparam int unsigned AW = sfrc_pkg::ACC_W;

  // ---------------------------------------------------------------
  // behaviour overview
  // ---------------------------------------------------------------
  // one 34-bit accumulator is the fractional numerator
  // auto mode: seg0 then seg1, each len+1 phase detector ticks
  // pin mode: every resynchronised step clock rise outside calibration is one step
  // direction pin picks the increment only in pin mode
  // clamping happens before the new value is stored
  // threshold of zero turns distance-based recalibration off
  // calibration ends on the calibrator's done pulse or the timer
  // timer counts state machine ticks from the cal clock divider
  // limitation: a pin step inside a calibration is lost for good
  // limitation: settings written mid-ramp act on the next tick
  // enable and mode must be set before the start bit is written

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic [5:0]  ctrl_q;
  logic [29:0] inc0_q, inc1_q;
  logic [15:0] len0_q, len1_q, callen_q;
  logic [AW-1:0] thr_q, llo_q, lhi_q;
  logic [1:0]  caldiv_q;
  logic        ack_q;
  sfrc_pkg::sfrc_req_s req;
  assign req.rd    = avs_read_in;
  assign req.wr    = avs_write_in;
  assign req.idx   = avs_address_in[5:2];
  assign req.wdata = avs_writedata_in;

  // one wait cycle per access: ack on second cycle of the request
  // writes land only at the edge that sees waitrequest low
  wire acc   = (req.rd | req.wr) & ~ack_q;
  wire wr_go = req.wr & ack_q;
  wire start_wr = wr_go & (req.idx == sfrc_pkg::IDX_CTRL) & req.wdata[sfrc_pkg::B_START];

  // ---------------------------------------------------------------
  // state machine clock divider
  // ---------------------------------------------------------------
  logic [7:0] div_q;
  wire [7:0] div_top = (8'h01 << caldiv_q) - 8'h01;
  wire sm_tick = (div_q >= div_top);
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) div_q <= 8'h00;
    else div_q <= sm_tick ? 8'h00 : div_q + 8'h01;
  end

  // ---------------------------------------------------------------
  // step pin resynchronisation
  // ---------------------------------------------------------------
  logic [2:0] sck_q;
  logic [1:0] sdir_q;
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      sck_q  <= 3'h0;
      sdir_q <= 2'h0;
    end else begin
      sck_q  <= {sck_q[1:0], step_clock_pin_in};
      sdir_q <= {sdir_q[0], step_direction_pin_in};
    end
  end
  wire sck_rise = sck_q[1] & ~sck_q[2];

  // ---------------------------------------------------------------
  // sequencer and accumulator
  // ---------------------------------------------------------------
  sfrc_pkg::sfrc_state_e st_q, st_d;
  logic [AW-1:0] acc_q, ref_q;
  logic [15:0] cnt_q, calc_q;
  logic        recal_q, started_q;
  wire en     = ctrl_q[sfrc_pkg::B_EN];
  wire manual = ctrl_q[sfrc_pkg::B_MAN];
  wire trig   = ctrl_q[sfrc_pkg::B_TRIG];
  wire busy   = (st_q == sfrc_pkg::SF_CAL);
  wire seg1   = (st_q == sfrc_pkg::SF_RUN1);
  // ramp tick: pin edge in pin mode, phase detector in auto mode
  wire auto_tick = en & ~manual & pd_tick_in & (st_q == sfrc_pkg::SF_RUN0 | seg1);
  wire pin_tick  = en & manual & sck_rise & ~busy;
  wire use1      = manual ? sdir_q[1] : seg1;
  wire [29:0] inc_sel = use1 ? inc1_q : inc0_q;
  wire [AW-1:0] inc_ext = {{(AW-30){inc_sel[29]}}, inc_sel};
  wire [AW-1:0] sum = acc_q + inc_ext;
  wire [AW-1:0] clamped = ($signed(sum) < $signed(llo_q)) ? llo_q :
                          ($signed(sum) > $signed(lhi_q)) ? lhi_q : sum;
  wire [AW-1:0] moved = clamped - ref_q;
  wire [AW-1:0] moved_abs = moved[AW-1] ? (~moved + 1'b1) : moved;
  wire thr_hit = (thr_q != '0) & (moved_abs >= thr_q);
  wire step = auto_tick | pin_tick;
  wire seg_end = auto_tick & (cnt_q == 16'h0000);
  wire new_seg = start_wr & en & ~manual | (seg_end & ~seg1);

  // next state of the automatic sequencer
  always_comb begin
    st_d = st_q;
    case (st_q)
      sfrc_pkg::SF_IDLE: if (start_wr & en & ~manual) st_d = trig ? sfrc_pkg::SF_CAL : sfrc_pkg::SF_RUN0;
      sfrc_pkg::SF_CAL:  if (cal_done_in | (sm_tick & calc_q == 16'h0000))
                           st_d = manual ? sfrc_pkg::SF_IDLE : (started_q ? sfrc_pkg::SF_RUN1 : sfrc_pkg::SF_RUN0);
      sfrc_pkg::SF_RUN0: if (seg_end) st_d = trig ? sfrc_pkg::SF_CAL : sfrc_pkg::SF_RUN1;
                         else if (step & thr_hit) st_d = sfrc_pkg::SF_CAL;
      sfrc_pkg::SF_RUN1: if (seg_end) st_d = sfrc_pkg::SF_IDLE;
                         else if (step & thr_hit) st_d = sfrc_pkg::SF_CAL;
      default:           st_d = sfrc_pkg::SF_IDLE;
    endcase
    if (!en) st_d = sfrc_pkg::SF_IDLE;
    else if (pin_tick & ((thr_hit) | trig)) st_d = sfrc_pkg::SF_CAL;
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      st_q <= sfrc_pkg::SF_IDLE;
      acc_q <= '0;
      ref_q <= '0;
      cnt_q <= sfrc_pkg::LEN_RST;
      calc_q <= 16'h0000;
      recal_q <= 1'b0;
      started_q <= 1'b0;
    end else begin
      st_q <= st_d;
      recal_q <= (st_d == sfrc_pkg::SF_CAL) & ~busy;
      if (step) acc_q <= clamped;
      if (st_d == sfrc_pkg::SF_CAL & ~busy) begin
        ref_q <= step ? clamped : acc_q;
        calc_q <= callen_q;
      end else if (busy & sm_tick & calc_q != 16'h0000) calc_q <= calc_q - 16'h0001;
      if (new_seg) begin
        cnt_q <= seg_end ? len1_q : len0_q;
        started_q <= seg_end;
      end else if (auto_tick) cnt_q <= cnt_q - 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // avalon slave: register writes and read mux
  // ---------------------------------------------------------------
  logic [31:0] rmux;
  always_comb begin
    case (req.idx)
      sfrc_pkg::IDX_CTRL:   rmux = {26'h0, ~busy & en & (st_q != sfrc_pkg::SF_IDLE), busy, 1'b0, ctrl_q[2:0]};
      sfrc_pkg::IDX_INC0:   rmux = {2'h0, inc0_q};
      sfrc_pkg::IDX_INC1:   rmux = {2'h0, inc1_q};
      sfrc_pkg::IDX_LEN:    rmux = {len1_q, len0_q};
      sfrc_pkg::IDX_THR_LO: rmux = thr_q[31:0];
      sfrc_pkg::IDX_THR_HI: rmux = {30'h0, thr_q[33:32]};
      sfrc_pkg::IDX_LLO_LO: rmux = llo_q[31:0];
      sfrc_pkg::IDX_LLO_HI: rmux = {30'h0, llo_q[33:32]};
      sfrc_pkg::IDX_LHI_LO: rmux = lhi_q[31:0];
      sfrc_pkg::IDX_LHI_HI: rmux = {30'h0, lhi_q[33:32]};
      sfrc_pkg::IDX_NUM_LO: rmux = acc_q[31:0];
      sfrc_pkg::IDX_NUM_HI: rmux = {30'h0, acc_q[33:32]};
      sfrc_pkg::IDX_CALDIV: rmux = {30'h0, caldiv_q};
      sfrc_pkg::IDX_CALLEN: rmux = {16'h0, callen_q};
      default:              rmux = sfrc_pkg::BUS_DEAD;
    endcase
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_q <= 6'h00;
      inc0_q <= 30'h0;
      inc1_q <= 30'h0;
      len0_q <= sfrc_pkg::LEN_RST;
      len1_q <= sfrc_pkg::LEN_RST;
      thr_q <= '0;
      llo_q <= {1'b1, 33'h0}; // limits reset to full range
      lhi_q <= {1'b0, {33{1'b1}}};
      caldiv_q <= 2'h0;
      callen_q <= sfrc_pkg::CALLEN_RST;
      ack_q <= 1'b0;
      avs_readdata_out <= 32'h0;
    end else begin
      ack_q <= acc;
      if (acc & req.rd) avs_readdata_out <= rmux;
      if (wr_go) begin
        case (req.idx)
          sfrc_pkg::IDX_CTRL:   ctrl_q[2:0] <= req.wdata[2:0];
          sfrc_pkg::IDX_INC0:   inc0_q <= req.wdata[29:0];
          sfrc_pkg::IDX_INC1:   inc1_q <= req.wdata[29:0];
          sfrc_pkg::IDX_LEN:    {len1_q, len0_q} <= req.wdata;
          sfrc_pkg::IDX_THR_LO: thr_q[31:0] <= req.wdata;
          sfrc_pkg::IDX_THR_HI: thr_q[33:32] <= req.wdata[1:0];
          sfrc_pkg::IDX_LLO_LO: llo_q[31:0] <= req.wdata;
          sfrc_pkg::IDX_LLO_HI: llo_q[33:32] <= req.wdata[1:0];
          sfrc_pkg::IDX_LHI_LO: lhi_q[31:0] <= req.wdata;
          sfrc_pkg::IDX_LHI_HI: lhi_q[33:32] <= req.wdata[1:0];
          sfrc_pkg::IDX_CALDIV: caldiv_q <= req.wdata[1:0];
          sfrc_pkg::IDX_CALLEN: callen_q <= req.wdata[15:0];
          default: ;
        endcase
      end
    end
  end

  assign avs_waitrequest_out = ~ack_q & (req.rd | req.wr);
  assign frac_numerator_out = acc_q;
  assign recal_req_out = recal_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_no_ramp_off: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    !en |=> $stable(acc_q)) else $error("numerator moved while ramp disabled");
  a_clamp_limits: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    step |=> ($signed(acc_q) >= $signed(llo_q) || $signed(llo_q) > $signed(lhi_q))) else $error("below low limit");
  a_busy_drop: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (busy & manual) |=> $stable(acc_q)) else $error("step taken during calibration");
  a_start_auto: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (st_q == sfrc_pkg::SF_IDLE && start_wr && en && !manual) |=> st_q != sfrc_pkg::SF_IDLE)
    else $error("start write ignored");
  a_seg_cal: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (en && trig && seg_end && st_q == sfrc_pkg::SF_RUN0) |=> recal_req_out) else $error("no recal at segment");
  a_step_add: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (step && sum == clamped) |=> acc_q == $past(sum)) else $error("increment not added");
  a_thr_cal: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (step && thr_hit && !busy && en) |=> busy) else $error("threshold recal missed");
  a_seg_len: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (auto_tick && cnt_q != 16'h0000) |=> cnt_q == $past(cnt_q) - 16'h0001) else $error("segment count slip");

  // no pin edge and no auto tick: numerator must hold
  a_pin_gate: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (!sck_rise && !auto_tick) |=> $stable(acc_q))
    else $error("numerator moved without a tick");

  // pin mode ignores the phase detector ticks
  a_auto_gate: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (manual && !pin_tick) |=> $stable(acc_q))
    else $error("pin mode stepped on a detector tick");

  // direction low adds the first increment, sign extended
  a_dir_low: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (pin_tick && !sdir_q[1] && sum == clamped) |=> (acc_q - $past(acc_q)) == {{4{$past(inc0_q[29])}}, $past(inc0_q)})
    else $error("low direction step wrong");

  // direction high adds the second increment, sign extended
  a_dir_high: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (pin_tick && sdir_q[1] && sum == clamped) |=> (acc_q - $past(acc_q)) == {{4{$past(inc1_q[29])}}, $past(inc1_q)})
    else $error("high direction step wrong");

  // upper bound never exceeded after a step
  a_high_limit: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    step |=> ($signed(acc_q) <= $signed(lhi_q) || $signed(llo_q) > $signed(lhi_q)))
    else $error("above high limit");

  // second segment is the last one
  a_two_seg: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (st_q == sfrc_pkg::SF_RUN1 && seg_end) |=> st_q == sfrc_pkg::SF_IDLE)
    else $error("ramp ran past second segment");

  // recalibration request is a single-cycle pulse
  a_recal_pulse: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    recal_req_out |=> !recal_req_out)
    else $error("recal request stuck high");

  // calibration holds until done or timer expiry
  a_cal_hold: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (busy && en && !cal_done_in && !(sm_tick && calc_q == 16'h0000)) |=> busy)
    else $error("calibration ended early");

  // start with recal at segment start goes through calibration first
  a_start_cal: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (st_q == sfrc_pkg::SF_IDLE && start_wr && en && !manual && trig) |=> busy)
    else $error("start skipped segment recal");

  // accumulator moves only on ramp ticks
  a_acc_hold: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    !step |=> $stable(acc_q))
    else $error("accumulator moved off a tick");
endmodule : sfrc_ramp
`default_nettype wire

/* File: rtl/sfrc_pkg.sv */
// constants and carrier types for the frequency ramp controller
// Functional notes
// - no ramping of any kind unless ramp enable is set
// - auto mode steps on phase detector ticks; pin mode steps on step clock rising edges
// - each ramp tick adds the active segment increment (30 bits) to the numerator
// - each segment lasts its programmed 16-bit count of ramp ticks; the code runs count+1 ticks per segment
// - force recalibration when numerator moved by threshold since last calibration
// - when enabled, force recalibration at the start of every segment
// - numerator is clamped to the low and high limits
// - step clock rising edges are resynchronised before use
// - step clock edges during a calibration are discarded
// - pin mode: direction low adds first increment, high adds second
// - auto mode runs up to two preset linear segments
// - writing the calibration start bit starts the automatic ramp
// - increments are two's complement, negative steps go down
`default_nettype none
package sfrc_pkg;
  // ---------------------------------------------------------------
  // register map (byte addresses, word index = address / 4)
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] IDX_CTRL   = 4'h0; // en, manual, trig_cal, cal_start, cal_busy
  localparam logic [3:0] IDX_INC0   = 4'h1;
  localparam logic [3:0] IDX_INC1   = 4'h2;
  localparam logic [3:0] IDX_LEN    = 4'h3; // [15:0] seg0, [31:16] seg1
  localparam logic [3:0] IDX_THR_LO = 4'h4;
  localparam logic [3:0] IDX_THR_HI = 4'h5; // bits 33:32 of threshold
  localparam logic [3:0] IDX_LLO_LO = 4'h6;
  localparam logic [3:0] IDX_LLO_HI = 4'h7;
  localparam logic [3:0] IDX_LHI_LO = 4'h8;
  localparam logic [3:0] IDX_LHI_HI = 4'h9;
  localparam logic [3:0] IDX_NUM_LO = 4'ha; // read: accumulator low word
  localparam logic [3:0] IDX_NUM_HI = 4'hb; // read: accumulator high bits
  localparam logic [3:0] IDX_CALDIV = 4'hc; // [1:0] cal clock divider exponent
  localparam logic [3:0] IDX_CALLEN = 4'hd; // [15:0] calibration time in sm ticks
  // control bit positions
  localparam int unsigned B_EN = 0;
  localparam int unsigned B_MAN = 1;
  localparam int unsigned B_TRIG = 2;
  localparam int unsigned B_START = 3;
  localparam int unsigned B_BUSY = 4;
  localparam int unsigned B_RUN = 5;
  // widths
  localparam int unsigned INC_W = 30;
  localparam int unsigned LEN_W = 16;
  localparam int unsigned ACC_W = 34; // 33 bits plus sign
  localparam logic [15:0] CALLEN_RST = 16'h0010;
  localparam logic [LEN_W-1:0] LEN_RST = 16'h0000;
  localparam logic [31:0] BUS_DEAD = 32'h0000_0000;
  // ramp sequencer states
  typedef enum logic [3:0] {
    SF_IDLE = 4'b0001,
    SF_CAL  = 4'b0010,
    SF_RUN0 = 4'b0100,
    SF_RUN1 = 4'b1000
  } sfrc_state_e;
  // avalon request carrier
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [3:0]  idx;
    logic [31:0] wdata;
  } sfrc_req_s;
endpackage : sfrc_pkg
`default_nettype wire

/* File: dv/sfrc_far_end.sv */
// far-side model: step pin driver and vco calibrator
`default_nettype none
module sfrc_far_end (
  input  wire logic clk_sys_in,
  input  wire logic go_in,
  input  wire logic dir_in,
  input  wire logic slow_in,
  input  wire logic recal_req_in,
  output logic      step_clock_pin_out,
  output logic      step_direction_pin_out,
  output logic      cal_done_out,
  output logic      busy_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0]  sc_q = 10'h000;
  logic [10:0] cc_q = 11'h000;
  initial step_direction_pin_out = 1'b0;
  // ----------------------------------------------------------------
  // step pins
  // ----------------------------------------------------------------
  // 1000-cycle period keeps the step clock at 250 kHz; direction settles 250 cycles before the edge
  always @(posedge clk_sys_in) begin
    if (go_in && sc_q == 10'h000) begin
      sc_q <= 10'h001;
      step_direction_pin_out <= dir_in;
    end else if (sc_q != 10'h000) begin
      sc_q <= (sc_q == 10'h3e7) ? 10'h000 : sc_q + 10'h001;
    end
  end
  assign step_clock_pin_out = (sc_q >= 10'h0fa) && (sc_q < 10'h2ee);
  assign busy_out = (sc_q != 10'h000);
  // ----------------------------------------------------------------
  // calibrator
  // ----------------------------------------------------------------
  // slow answer outlasts a whole step period so a step lands inside the calibration
  always @(posedge clk_sys_in) begin
    if (recal_req_in) begin
      cc_q <= slow_in ? 11'h5dc : 11'h00a;
    end else if (cc_q != 11'h000) begin
      cc_q <= cc_q - 11'h001;
    end
  end
  assign cal_done_out = (cc_q == 11'h001);
endmodule // sfrc_far_end
`default_nettype wire

/* File: dv/sfrc_ramp_test.sv */
// self-checking bench for the frequency ramp controller
`default_nettype none
module sfrc_ramp_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys_in = 1'b0, rst_in = 1'b1, pd_tick = 1'b0, go = 1'b0, dir = 1'b0;
  logic        slow = 1'b1, rd = 1'b0, wr = 1'b0, sclk, sdir, cdone, rreq, wreq, busy;
  logic [5:0]  addr = 6'h00;
  logic [31:0] wd = 32'h0000_0000, rdata, q;
  logic [33:0] num;
  logic [63:0] me;
  logic [63:0] exq[$];
  int          num_errors = 0, total_checks = 0, cyc = 0, rc = 0, rc0 = 0;
  always #2 clk_sys_in = ~clk_sys_in;
  sfrc_ramp dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .pd_tick_in(pd_tick), .step_clock_pin_in(sclk),
    .step_direction_pin_in(sdir), .cal_done_in(cdone), .avs_address_in(addr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wd), .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
    .frac_numerator_out(num), .recal_req_out(rreq));
  sfrc_far_end far (.clk_sys_in(clk_sys_in), .go_in(go), .dir_in(dir), .slow_in(slow), .recal_req_in(rreq),
    .step_clock_pin_out(sclk), .step_direction_pin_out(sdir), .cal_done_out(cdone), .busy_out(busy));
  // ----------------------------------------------------------------
  // free-running stimulus, pulse counting and hang guard
  // ----------------------------------------------------------------
  always @(posedge clk_sys_in) begin
    pd_tick <= 1'($urandom_range(1, 0));
    cyc++;
    if (rreq === 1'b1) rc++;
    if (cyc == 60000) begin
      num_errors++;
      $display("BAD %0t run did not finish", $time);
      results();
    end
  end
  // read results are matched against the oldest note, masked bits ignored
  always @(posedge clk_sys_in) begin
    if (rd && wreq === 1'b0) begin
      me = exq.pop_front();
      total_checks++;
      if (((rdata ^ me[31:0]) & me[63:32]) !== 32'h0000_0000) begin
        num_errors++;
        $display("BAD %0t read %h want %h", $time, rdata, me[31:0]);
      end
    end
  end
  task results();
    if (num_errors == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic [33:0] g, input logic [33:0] e);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  // request held until waitrequest is seen low, released on the following edge
  task bus(input logic w, input logic [3:0] i, input logic [31:0] d, input logic [31:0] m, input logic [31:0] e);
    int n;
    n = 0;
    @(posedge clk_sys_in);
    addr <= {i, 2'b00};
    rd <= !w;
    wr <= w;
    wd <= d;
    if (!w) exq.push_back({m, e});
    @(negedge clk_sys_in);
    while (wreq !== 1'b0 && n < 50) begin
      @(negedge clk_sys_in);
      n++;
    end
    q = rdata;
    @(posedge clk_sys_in);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task bw(input logic [3:0] i, input logic [31:0] d);
    bus(1'b1, i, d, 32'h0000_0000, 32'h0000_0000);
  endtask
  task rdc(input logic [3:0] i, input logic [31:0] e);
    bus(1'b0, i, 32'h0000_0000, 32'hffff_ffff, e);
  endtask
  task step(input logic d);
    int n;
    n = 0;
    @(posedge clk_sys_in);
    go <= 1'b1;
    dir <= d;
    @(posedge clk_sys_in);
    go <= 1'b0;
    @(negedge clk_sys_in);
    while (busy === 1'b1 && n < 2000) begin
      @(negedge clk_sys_in);
      n++;
    end
  endtask
  // polls control until neither busy nor running
  task waitrun();
    int i;
    for (i = 0; i < 200; i++) begin
      bus(1'b0, sfrc_pkg::IDX_CTRL, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
      if (i > 3 && q[5:4] == 2'b00) break;
    end
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h50f6));
    // cal divider left at reset: state machine ticks on every system clock cycle
    repeat (20) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    bw(sfrc_pkg::IDX_CALLEN, 32'h0000_ffff);
    bw(sfrc_pkg::IDX_THR_LO, 32'h0000_0008);
    bw(sfrc_pkg::IDX_INC0, 32'h0000_0005);
    bw(sfrc_pkg::IDX_INC1, 32'h3fff_fffd);
    bw(sfrc_pkg::IDX_CTRL, 32'h0000_0002);
    bw(4'he, 32'hffff_ffff);
    rdc(4'he, 32'h0000_0000);
    step(1'b0);
    chk(num, 34'h0);
    bw(sfrc_pkg::IDX_CTRL, 32'h0000_0003);
    step(1'b0);
    chk(num, 34'h5);
    step(1'b1);
    chk(num, 34'h2);
    step(1'b0);
    step(1'b0);
    chk(34'(rc), 34'h1);
    step(1'b0);
    chk(num, 34'hc);
    slow <= 1'b0;
    bw(sfrc_pkg::IDX_THR_LO, 32'h0000_0000);
    bw(sfrc_pkg::IDX_LHI_LO, 32'h0000_000e);
    bw(sfrc_pkg::IDX_LHI_HI, 32'h0000_0000);
    bw(sfrc_pkg::IDX_INC1, 32'h3fff_ffec);
    step(1'b0);
    chk(num, 34'he);
    bw(sfrc_pkg::IDX_LLO_LO, 32'hffff_fffe);
    bw(sfrc_pkg::IDX_LLO_HI, 32'h0000_0003);
    step(1'b1);
    chk(num, 34'h3_ffff_fffe);
    rdc(sfrc_pkg::IDX_NUM_LO, 32'hffff_fffe);
    rdc(sfrc_pkg::IDX_NUM_HI, 32'h0000_0003);
    rst_in <= 1'b1;
    repeat (20) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    chk(num, 34'h0);
    bw(sfrc_pkg::IDX_INC0, 32'h0000_000a);
    bw(sfrc_pkg::IDX_INC1, 32'h3fff_fffc);
    bw(sfrc_pkg::IDX_LEN, 32'h0001_0003);
    bw(sfrc_pkg::IDX_CTRL, 32'h0000_0001);
    rc = 0;
    bw(sfrc_pkg::IDX_CTRL, 32'h0000_0009);
    waitrun();
    chk(num, 34'h20);
    rdc(sfrc_pkg::IDX_NUM_LO, 32'h0000_0020);
    rc0 = rc;
    bw(sfrc_pkg::IDX_CTRL, 32'h0000_0005);
    bw(sfrc_pkg::IDX_CTRL, 32'h0000_000d);
    waitrun();
    chk(num, 34'h40);
    chk(34'(rc - 2 * rc0), 34'h2);
    bw(sfrc_pkg::IDX_CTRL, 32'h0000_0008);
    waitrun();
    chk(num, 34'h40);
    results();
  end
endmodule // sfrc_ramp_test
`default_nettype wire
